//--- csr_pkg.sv
// Purpose: shared constants and types for console select / rotate control
// Assumes: 18-bit display-file words, word bit 17-n carries instruction bit n
// Notes: register map is word aligned on a plain strobe port
package csr_pkg;
  // opcode field is instruction bits 0..3 = word[17:14]; octal 34 over the top six bits
  localparam logic [3:0] CSEL_OP = 4'h7;
  localparam int OP_HI = 17;
  localparam int OP_LO = 14;
  // console-select fields, unit 0 first
  localparam int INT_U0 = 6;
  localparam int PEN_U0 = 7;
  // skip-1 unit address: bits 16,17
  localparam int SKIP_UNIT_HI = 1;
  // parameter-2 rotate enable (bit 12) and rotate select (bit 13)
  localparam int ROT_ENA_POS = 5;
  localparam int ROT_SEL_POS = 4;

  localparam int AW = 8;
  localparam int DW = 32;
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_STATE = 8'h0C;
  localparam int EV_HIT = 0;
  localparam int EV_SENSE = 1;
  localparam int EV_SETTLE = 2;
  localparam int NEV = 3;
  localparam int CTRL_RESUME = 0;
  localparam int CTRL_GPEN = 1;
  localparam int CTRL_GINT = 2;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic CTRL_GPEN_RST = 1'b1;
  localparam logic CTRL_GINT_RST = 1'b1;

  localparam int CLK_NS = 5;
  localparam int SETTLE_NS = 20000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 12;
  localparam int DAC_W = 10;
  localparam int DAC_SETUP_NS = 20;
  localparam int DAC_HOLD_NS = 5;
  localparam int DAC_PW_POS_NS = 50;
  localparam int DAC_PW_NEG_NS = 30;
  localparam int DAC_SETUP_CYC = (DAC_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int DAC_PW_POS_CYC = (DAC_PW_POS_NS + CLK_NS - 1) / CLK_NS;
  localparam int DAC_PW_NEG_CYC = (DAC_PW_NEG_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    CSR_MV_BVEC = 3'h0,
    CSR_MV_BSVEC = 3'h1,
    CSR_MV_CHAR = 3'h2,
    CSR_MV_CSTR = 3'h3,
    CSR_MV_POINT = 3'h4,
    CSR_MV_ARBV = 3'h5,
    CSR_MV_ARBSV = 3'h6,
    CSR_MV_GRAPH = 3'h7
  } csr_move_e;

  typedef enum logic [1:0] {
    CSR_DAC_IDLE = 2'h0,
    CSR_DAC_SETUP = 2'h1,
    CSR_DAC_PULSE = 2'h2
  } csr_dac_e;
endpackage : csr_pkg

//--- csr_dac_if.sv
// Purpose: load request path from the controller to one deflection converter loader
// Assumes: single core_clk domain
// Notes: busy is combinational from loader state
`timescale 1ns/100ps
`default_nettype none
interface csr_dac_if;
  logic req;
  logic [9:0] data;
  logic busy;
  modport ctrl (output req, output data, input busy);
  modport conv (input req, input data, output busy);
endinterface : csr_dac_if
`default_nettype wire

//--- csr_dac_load.sv
// Purpose: drive one deflection converter's 10-bit input register and load pulse
// Assumes: data pins settle one full setup time before the leading edge
// Notes: LOAD_POS selects a rising or falling leading edge on dac_clk
`timescale 1ns/100ps
`default_nettype none
module csr_dac_load #(
  parameter bit LOAD_POS = 1'b1,
  parameter int PW_CYC = csr_pkg::DAC_PW_POS_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  csr_dac_if.conv bus,
  output logic [9:0] dac_data,
  output logic dac_clk,
  output logic [9:0] dac_held
);
  typedef struct packed {
    csr_pkg::csr_dac_e st;
    logic [3:0] cnt;
    logic pulse;
    logic [9:0] data;
    logic [9:0] held;
  } csr_dac_s;

  csr_dac_s s_reg;
  csr_dac_s s_next;

  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      csr_pkg::CSR_DAC_IDLE: begin
        if (bus.req) begin
          s_next.data = bus.data;
          s_next.cnt = 4'(csr_pkg::DAC_SETUP_CYC - 1);
          s_next.st = csr_pkg::CSR_DAC_SETUP;
        end
      end
      csr_pkg::CSR_DAC_SETUP: begin
        if (s_reg.cnt == 4'h0) begin
          // leading edge: converter register takes the pins now
          s_next.pulse = 1'b1; // see RULE12
          s_next.held = s_reg.data;
          s_next.cnt = 4'(PW_CYC - 1);
          s_next.st = csr_pkg::CSR_DAC_PULSE;
        end else begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end
      end
      csr_pkg::CSR_DAC_PULSE: begin
        if (s_reg.cnt == 4'h0) begin
          s_next.pulse = 1'b0;
          s_next.st = csr_pkg::CSR_DAC_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end
      end
      default: s_next.st = csr_pkg::CSR_DAC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.busy = (s_reg.st != csr_pkg::CSR_DAC_IDLE);
  assign dac_data = s_reg.data;
  // idle level is the trailing level of the fitted variant
  assign dac_clk = LOAD_POS ? s_reg.pulse : ~s_reg.pulse; // see RULE13
  assign dac_held = s_reg.held;

  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_dac_capture: assert property ( // see RULE12
    $rose(s_reg.pulse) |-> (dac_held == dac_data) && $stable(dac_data))
    else $error("converter register missed data at leading edge");
  a_dac_polarity: assert property ( // see RULE13
    $rose(s_reg.pulse) |-> (dac_clk == LOAD_POS))
    else $error("load pulse leading edge has wrong polarity");
  a_dac_setup_width: assert property ( // see RULE12
    (bus.req && !bus.busy) |=> !s_reg.pulse [*4] ##1 s_reg.pulse)
    else $error("load pulse setup time wrong");
  c_dac_load: cover property ($fell(s_reg.pulse));
endmodule : csr_dac_load
`default_nettype wire

//--- csr_ctrl.sv
// Purpose: console select, skip unit address, rotation and sector re-entry control
// Assumes: instruction and move strobes come from core_clk logic; console pins do not
// Notes: status bits are write-one-to-clear, an event in the clearing cycle survives
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Function
// RULE1 - console-select recognised by opcode octal 34 in instruction bits 0 to 3
// RULE2 - console-select bits 4 to 9 are ignored
// RULE3 - bits 11,13,15,17 enable intensity of units 00 to 03
// RULE4 - bits 10,12,14,16 enable light pens of units 00 to 03
// RULE5 - enabled pen hit halts display; pen sense alone does not halt
// RULE6 - with multiplexer fitted, skip-1 bits 16,17 address the tested console
// RULE7 - global pen and intensity control unchanged; unit bits give selectivity
// RULE8 - active rotation turns output 90 degrees counterclockwise
// RULE9 - rotation only for basic vector, short vector, character, character string
// RULE10 - parameter-2 bit 12 is rotate enable, bit 13 rotate select
// RULE11 - re-entering sector 0 by character or vector inserts a 20 us wait
// RULE12 - each converter input register captures data on load pulse leading edge
// RULE13 - load pulse polarity matches the fitted converter variant
// RULE14 - re-entry wait is a clock-cycle counter covering the settling time
module csr_ctrl #(
  parameter logic [3:0] PARAM2_OP = 4'h0,
  parameter logic [3:0] SKIP1_OP = 4'h1,
  parameter bit X_LOAD_POS = 1'b1,
  parameter bit Y_LOAD_POS = 1'b0
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic [17:0] instr_word,
  input wire logic mux_fitted,
  input wire logic [3:0] pen_hit_flag,
  input wire logic [3:0] pen_sense_in,
  input wire logic move_valid,
  input wire logic [2:0] move_kind,
  input wire logic signed [9:0] move_dx,
  input wire logic signed [9:0] move_dy,
  input wire logic beam_sector0,
  input wire logic draw_active,
  input wire logic x_load,
  input wire logic [9:0] x_data,
  input wire logic y_load,
  input wire logic [9:0] y_data,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic [3:0] console_intensify_enable,
  output logic [3:0] pen_enable_bit,
  output logic pen_sense_indicator,
  output logic halt_display,
  output logic [1:0] skip_unit,
  output logic skip_unit_valid,
  output logic turn_enable_bit,
  output logic out_valid,
  output logic signed [9:0] out_dx,
  output logic signed [9:0] out_dy,
  output logic settle_wait,
  output logic x_busy,
  output logic [9:0] dac_x_data,
  output logic dac_x_clk,
  output logic y_busy,
  output logic [9:0] dac_y_data,
  output logic dac_y_clk
);
  typedef struct packed {
    logic [3:0] hit_m;
    logic [3:0] hit_s;
    logic [3:0] sense_m;
    logic [3:0] sense_s;
    logic mux_m;
    logic mux_s;
    logic [3:0] inten;
    logic [3:0] pen;
    logic halt;
    logic sense;
    logic rot_on;
    logic [1:0] skip_unit;
    logic skip_stb;
    logic sec_prev;
    logic [11:0] settle_cnt;
    logic [2:0] status;
    logic [2:0] mask;
    logic gpen;
    logic gint;
    logic [31:0] rdata;
    logic signed [9:0] rdx;
    logic signed [9:0] rdy;
    logic rvalid;
  } csr_state_s;

  csr_state_s s_reg;
  csr_state_s s_next;
  logic [3:0] opcode;
  logic hit_ev;
  logic sense_ev;
  logic reentry;
  logic settle_done;
  logic rotatable;
  logic wr_status;
  logic wr_mask;
  logic wr_ctrl;
  logic [2:0] ev;

  csr_dac_if x_if ();
  csr_dac_if y_if ();

  assign opcode = instr_word[csr_pkg::OP_HI:csr_pkg::OP_LO];
  // synchronised copies only; pens are gated per console and by the global enable
  assign hit_ev = |(s_reg.hit_s & s_reg.pen) & s_reg.gpen; // see RULE5
  assign sense_ev = |(s_reg.sense_s & s_reg.pen) & s_reg.gpen;
  assign reentry = draw_active && beam_sector0 && !s_reg.sec_prev; // see RULE11
  assign settle_done = (s_reg.settle_cnt == 12'h001);
  assign rotatable = (move_kind == csr_pkg::CSR_MV_BVEC) ||
                     (move_kind == csr_pkg::CSR_MV_BSVEC) ||
                     (move_kind == csr_pkg::CSR_MV_CHAR) ||
                     (move_kind == csr_pkg::CSR_MV_CSTR); // see RULE9
  assign wr_status = reg_we && (reg_addr == csr_pkg::OFF_STATUS);
  assign wr_mask = reg_we && (reg_addr == csr_pkg::OFF_MASK);
  assign wr_ctrl = reg_we && (reg_addr == csr_pkg::OFF_CTRL);
  assign ev = {settle_done, sense_ev, hit_ev};

  always_comb begin
    s_next = s_reg;
    s_next.hit_m = pen_hit_flag;
    s_next.hit_s = s_reg.hit_m;
    s_next.sense_m = pen_sense_in;
    s_next.sense_s = s_reg.sense_m;
    s_next.mux_m = mux_fitted;
    s_next.mux_s = s_reg.mux_m;
    s_next.skip_stb = 1'b0;
    s_next.rvalid = 1'b0;
    s_next.rdata = 32'h00000000;
    s_next.sec_prev = beam_sector0;
    s_next.sense = sense_ev; // see RULE5
    if (instr_valid) begin
      if (opcode == csr_pkg::CSEL_OP) begin // see RULE1
        // only the odd/even unit bits are taken, bits 4..9 never looked at
        s_next.inten = {instr_word[csr_pkg::INT_U0 - 6], instr_word[csr_pkg::INT_U0 - 4],
                        instr_word[csr_pkg::INT_U0 - 2], instr_word[csr_pkg::INT_U0]}; // see RULE3
        s_next.pen = {instr_word[csr_pkg::PEN_U0 - 6], instr_word[csr_pkg::PEN_U0 - 4],
                      instr_word[csr_pkg::PEN_U0 - 2], instr_word[csr_pkg::PEN_U0]}; // see RULE4
      end else if (opcode == PARAM2_OP) begin
        if (instr_word[csr_pkg::ROT_ENA_POS]) begin // see RULE10
          s_next.rot_on = instr_word[csr_pkg::ROT_SEL_POS];
        end
      end else if (opcode == SKIP1_OP) begin
        // without the multiplexer only unit 0 exists
        s_next.skip_unit = s_reg.mux_s ? instr_word[csr_pkg::SKIP_UNIT_HI:0] : 2'h0; // see RULE6
        s_next.skip_stb = 1'b1;
      end
    end
    if (wr_ctrl && reg_wdata[csr_pkg::CTRL_RESUME]) begin
      s_next.halt = 1'b0;
    end
    if (hit_ev) begin
      s_next.halt = 1'b1; // see RULE5
    end
    if (reentry) begin
      s_next.settle_cnt = 12'(csr_pkg::SETTLE_CYC); // see RULE14
    end else if (s_reg.settle_cnt != 12'h000) begin
      s_next.settle_cnt = s_reg.settle_cnt - 12'h001;
    end
    if (move_valid) begin
      s_next.rvalid = 1'b1;
      if (s_reg.rot_on && rotatable) begin
        // counterclockwise quarter turn: (x, y) -> (-y, x)
        s_next.rdx = -move_dy; // see RULE8
        s_next.rdy = move_dx;
      end else begin
        s_next.rdx = move_dx;
        s_next.rdy = move_dy;
      end
    end
    if (wr_status) begin
      s_next.status = s_reg.status & ~reg_wdata[csr_pkg::NEV - 1:0];
    end
    s_next.status = s_next.status | ev;
    if (wr_mask) begin
      s_next.mask = reg_wdata[csr_pkg::NEV - 1:0];
    end
    if (wr_ctrl) begin
      s_next.gpen = reg_wdata[csr_pkg::CTRL_GPEN];
      s_next.gint = reg_wdata[csr_pkg::CTRL_GINT];
    end
    if (reg_re) begin
      if (reg_addr == csr_pkg::OFF_STATUS) begin
        s_next.rdata = {29'h0, s_reg.status};
      end else if (reg_addr == csr_pkg::OFF_MASK) begin
        s_next.rdata = {29'h0, s_reg.mask};
      end else if (reg_addr == csr_pkg::OFF_CTRL) begin
        s_next.rdata = {29'h0, s_reg.gint, s_reg.gpen, 1'b0};
      end else if (reg_addr == csr_pkg::OFF_STATE) begin
        s_next.rdata = {17'h0, s_reg.mux_s, s_reg.skip_unit, (s_reg.settle_cnt != 12'h000),
                        s_reg.rot_on, s_reg.sense, s_reg.halt, s_reg.pen, s_reg.inten};
      end else begin
        s_next.rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.mask <= csr_pkg::MASK_RST;
      s_reg.gpen <= csr_pkg::CTRL_GPEN_RST;
      s_reg.gint <= csr_pkg::CTRL_GINT_RST;
      s_reg.sec_prev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // global parameter-instruction control still applies to every console
  assign console_intensify_enable = s_reg.inten & {4{s_reg.gint}}; // see RULE7
  assign pen_enable_bit = s_reg.pen & {4{s_reg.gpen}}; // see RULE7
  assign pen_sense_indicator = s_reg.sense;
  assign halt_display = s_reg.halt;
  assign skip_unit = s_reg.skip_unit;
  assign skip_unit_valid = s_reg.skip_stb;
  assign turn_enable_bit = s_reg.rot_on;
  assign out_valid = s_reg.rvalid;
  assign out_dx = s_reg.rdx;
  assign out_dy = s_reg.rdy;
  assign settle_wait = (s_reg.settle_cnt != 12'h000); // see RULE11
  assign reg_rdata = s_reg.rdata;
  assign irq = |(s_reg.status & s_reg.mask);

  // a load arriving while its converter is busy is dropped
  assign x_if.req = x_load;
  assign x_if.data = x_data;
  assign y_if.req = y_load;
  assign y_if.data = y_data;
  assign x_busy = x_if.busy;
  assign y_busy = y_if.busy;

  csr_dac_load #(
    .LOAD_POS(X_LOAD_POS),
    .PW_CYC(X_LOAD_POS ? csr_pkg::DAC_PW_POS_CYC : csr_pkg::DAC_PW_NEG_CYC)
  ) u_dac_x (
    .core_clk(core_clk),
    .nrst(nrst),
    .bus(x_if.conv),
    .dac_data(dac_x_data),
    .dac_clk(dac_x_clk),
    .dac_held()
  );

  csr_dac_load #(
    .LOAD_POS(Y_LOAD_POS),
    .PW_CYC(Y_LOAD_POS ? csr_pkg::DAC_PW_POS_CYC : csr_pkg::DAC_PW_NEG_CYC)
  ) u_dac_y (
    .core_clk(core_clk),
    .nrst(nrst),
    .bus(y_if.conv),
    .dac_data(dac_y_data),
    .dac_clk(dac_y_clk),
    .dac_held()
  );

  default clocking mcb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_csel_decode: assert property ( // see RULE1
    (instr_valid && opcode != csr_pkg::CSEL_OP) |=> $stable(s_reg.inten) && $stable(s_reg.pen))
    else $error("console enables changed without console-select");
  a_csel_ignore_bits: assert property ( // see RULE2
    (instr_valid && opcode == csr_pkg::CSEL_OP) |=>
      s_reg.inten == {$past(instr_word[0]), $past(instr_word[2]),
                      $past(instr_word[4]), $past(instr_word[6])})
    else $error("console-select intensity depends on other bits");
  a_intens_unit: assert property ( // see RULE3
    (instr_valid && instr_word == 18'h1C010) |=> !s_reg.gint || console_intensify_enable == 4'h2)
    else $error("bit 13 alone did not enable only unit 01");
  a_pen_enable: assert property ( // see RULE4
    (instr_valid && opcode == csr_pkg::CSEL_OP) |=> s_reg.pen[0] == $past(instr_word[7]))
    else $error("unit 00 pen enable not taken from bit 10");
  a_halt_on_hit: assert property ( // see RULE5
    hit_ev |=> halt_display)
    else $error("enabled pen hit did not halt display");
  a_sense_no_halt: assert property ( // see RULE5
    (!halt_display && !hit_ev && sense_ev) |=> !halt_display && pen_sense_indicator)
    else $error("pen sense alone halted display");
  a_skip_unit: assert property ( // see RULE6
    (instr_valid && opcode == SKIP1_OP) |=> skip_unit_valid &&
      (skip_unit == ($past(s_reg.mux_s) ? $past(instr_word[1:0]) : 2'h0)))
    else $error("skip-1 unit address wrong");
  a_global_gate: assert property ( // see RULE7
    !s_reg.gpen |-> pen_enable_bit == 4'h0)
    else $error("pen enabled while globally disabled");
  a_rotate_ccw: assert property ( // see RULE8
    (move_valid && s_reg.rot_on && rotatable) |=> out_dx == -$past(move_dy) &&
      out_dy == $past(move_dx))
    else $error("rotation is not a counterclockwise quarter turn");
  a_rotate_only_basic: assert property ( // see RULE9
    (move_valid && !rotatable) |=> out_dx == $past(move_dx) && out_dy == $past(move_dy))
    else $error("non-basic instruction was rotated");
  a_rotate_latch: assert property ( // see RULE10
    (instr_valid && opcode == PARAM2_OP && !instr_word[csr_pkg::ROT_ENA_POS] &&
     !(opcode == csr_pkg::CSEL_OP)) |=> $stable(turn_enable_bit))
    else $error("rotate changed without rotate enable");
  a_settle_start: assert property ( // see RULE11
    reentry |=> settle_wait && s_reg.settle_cnt == 12'(csr_pkg::SETTLE_CYC))
    else $error("re-entry wait not started at full length");
  a_settle_count: assert property ( // see RULE14
    (settle_wait && !reentry) |=> s_reg.settle_cnt == $past(s_reg.settle_cnt) - 12'h001)
    else $error("re-entry counter did not step");
  a_status_set_wins: assert property (
    hit_ev |=> s_reg.status[csr_pkg::EV_HIT])
    else $error("pen hit event lost");

  c_csel: cover property (instr_valid && opcode == csr_pkg::CSEL_OP);
  c_halt: cover property ($rose(halt_display));
  c_rotate: cover property (move_valid && s_reg.rot_on && rotatable);
  c_settle_done: cover property (settle_done);
endmodule : csr_ctrl
`default_nettype wire

//--- csr_console_model.sv
// Purpose: behavioural consoles with light pens facing the control block
// Assumes: a pen only reacts to light from a console that is intensified
// Notes: aim picks the consoles whose pens see the beam
`timescale 1ns/100ps
`default_nettype none
module csr_console_model (
  input wire logic [3:0] console_intensify_enable,
  input wire logic [3:0] aim,
  input wire logic want_hit,
  input wire logic want_sense,
  output logic [3:0] pen_hit_flag,
  output logic [3:0] pen_sense_in
);
  // a blanked console gives the pen nothing to see
  always_comb begin
    pen_hit_flag = want_hit ? (aim & console_intensify_enable) : 4'h0;
    pen_sense_in = want_sense ? (aim & console_intensify_enable) : 4'h0;
  end
endmodule : csr_console_model
`default_nettype wire

//--- test_console_select_rotate_control.sv
// Purpose: self-checking bench for console select, skip unit, rotation and settle wait
// Assumes: inputs change by non-blocking assignment just after a rising edge
// Notes: every wait is bounded and a spent bound ends the run
`timescale 1ns/100ps
`default_nettype none
module test_console_select_rotate_control;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic instr_valid = 1'b0;
  logic [17:0] instr_word = 18'h0;
  logic mux_fitted = 1'b0;
  logic [3:0] aim = 4'h0;
  logic want_hit = 1'b0;
  logic want_sense = 1'b0;
  logic move_valid = 1'b0;
  logic [2:0] move_kind = 3'h0;
  logic signed [9:0] move_dx = 10'sh3;
  logic signed [9:0] move_dy = 10'sh5;
  logic beam_sector0 = 1'b1;
  logic draw_active = 1'b0;
  logic x_load = 1'b0, y_load = 1'b0;
  logic [9:0] x_data = 10'h0, y_data = 10'h0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, r;
  logic reg_we = 1'b0, reg_re = 1'b0;
  logic irq, pen_sense_indicator, halt_display, skip_unit_valid, turn_enable_bit;
  logic out_valid, settle_wait, x_busy, y_busy, dac_x_clk, dac_y_clk;
  logic [3:0] console_intensify_enable, pen_enable_bit, pen_hit_flag, pen_sense_in;
  logic [1:0] skip_unit;
  logic signed [9:0] out_dx, out_dy;
  logic [9:0] dac_x_data, dac_y_data;
  int n_mismatch = 0;
  int n_checks = 0;
  int i, n;

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  csr_ctrl DUT (.core_clk(core_clk), .nrst(nrst), .instr_valid(instr_valid),
    .instr_word(instr_word), .mux_fitted(mux_fitted), .pen_hit_flag(pen_hit_flag),
    .pen_sense_in(pen_sense_in), .move_valid(move_valid), .move_kind(move_kind),
    .move_dx(move_dx), .move_dy(move_dy), .beam_sector0(beam_sector0),
    .draw_active(draw_active), .x_load(x_load), .x_data(x_data), .y_load(y_load),
    .y_data(y_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq),
    .console_intensify_enable(console_intensify_enable), .pen_enable_bit(pen_enable_bit),
    .pen_sense_indicator(pen_sense_indicator), .halt_display(halt_display),
    .skip_unit(skip_unit), .skip_unit_valid(skip_unit_valid),
    .turn_enable_bit(turn_enable_bit), .out_valid(out_valid), .out_dx(out_dx),
    .out_dy(out_dy), .settle_wait(settle_wait), .x_busy(x_busy), .dac_x_data(dac_x_data),
    .dac_x_clk(dac_x_clk), .y_busy(y_busy), .dac_y_data(dac_y_data), .dac_y_clk(dac_y_clk));

  csr_console_model con (.console_intensify_enable(console_intensify_enable), .aim(aim),
    .want_hit(want_hit), .want_sense(want_sense), .pen_hit_flag(pen_hit_flag),
    .pen_sense_in(pen_sense_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic give_up(input int used, input int lim);
    if (used >= lim) begin
      n_mismatch++;
      $display("[FAIL] %0t wait ran out", $time);
      complete_run();
    end
  endtask : give_up

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_we <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic ins(input logic [17:0] w);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
  endtask : ins

  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : tick

  // measures data setup and pulse width in whole clocks
  task automatic dac(input bit is_x, input logic [9:0] d);
    int k;
    int w;
    @(posedge core_clk);
    if (is_x) x_load <= 1'b1;
    else y_load <= 1'b1;
    x_data <= d;
    y_data <= d;
    @(posedge core_clk);
    x_load <= 1'b0;
    y_load <= 1'b0;
    #1;
    chk(32'(is_x ? x_busy : y_busy), 32'h1);
    for (k = 0; k < 40 && (is_x ? dac_x_clk : dac_y_clk) === !is_x; k++) tick(1);
    give_up(k, 40);
    chk(32'(k >= csr_pkg::DAC_SETUP_CYC), 32'h1);
    chk(32'(is_x ? dac_x_data : dac_y_data), 32'(d));
    for (w = 0; w < 40 && (is_x ? dac_x_clk : dac_y_clk) === is_x; w++) tick(1);
    give_up(w, 40);
    chk(32'(is_x ? x_busy : y_busy), 32'h0);
    chk(32'(w >= (is_x ? csr_pkg::DAC_PW_POS_CYC : csr_pkg::DAC_PW_NEG_CYC)), 32'h1);
  endtask : dac

  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    rd(8'h04, r);
    chk(r, 32'h0);
    rd(8'h08, r);
    chk(r, 32'h6);
    rd(8'h10, r);
    chk(r, 32'h0);
    for (i = 0; i < 4; i++) begin
      ins(18'h1C000 | (18'h1 << (6 - 2 * i)));
      chk(32'(console_intensify_enable), 32'h1 << i);
      ins(18'h1C000 | (18'h1 << (7 - 2 * i)));
      chk(32'(pen_enable_bit), 32'h1 << i);
    end
    ins(18'h1FF40);
    chk(32'({pen_enable_bit, console_intensify_enable}), 32'h01);
    ins(18'h18010);
    chk(32'(console_intensify_enable), 32'h1);
    ins(18'h1C0F0);
    wr(8'h08, 32'h2);
    chk(32'({pen_enable_bit, console_intensify_enable}), 32'h30);
    wr(8'h08, 32'h6);
    chk(32'(console_intensify_enable), 32'h3);
    // sense masked off, hit unmasked
    wr(8'h04, 32'h1);
    aim <= 4'h2;
    want_sense <= 1'b1;
    tick(6);
    chk(32'({pen_sense_indicator, halt_display, irq}), 32'h4);
    want_sense <= 1'b0;
    aim <= 4'h1;
    want_hit <= 1'b1;
    for (i = 0; i < 8 && halt_display !== 1'b1; i++) tick(1);
    give_up(i, 8);
    chk(32'(irq), 32'h1);
    want_hit <= 1'b0;
    tick(4);
    rd(8'h00, r);
    chk(r, 32'h3);
    wr(8'h00, 32'h3);
    wr(8'h08, 32'h7);
    chk(32'({halt_display, irq}), 32'h0);
    mux_fitted <= 1'b1;
    tick(3);
    ins(18'h04002);
    chk(32'({skip_unit_valid, skip_unit}), 32'h6);
    rd(8'h0C, r);
    chk(r, 32'h6033);
    mux_fitted <= 1'b0;
    tick(3);
    ins(18'h04003);
    chk(32'(skip_unit), 32'h0);
    ins(18'h00030);
    ins(18'h00000);
    chk(32'(turn_enable_bit), 32'h1);
    for (i = 0; i < 9; i++) begin
      if (i == 8) ins(18'h00020);
      @(posedge core_clk);
      move_valid <= 1'b1;
      move_kind <= 3'(i);
      @(posedge core_clk);
      move_valid <= 1'b0;
      #1;
      chk(32'(out_valid), 32'h1);
      chk(32'(out_dx), (i < 4) ? -32'sd5 : 32'sd3);
      chk(32'(out_dy), (i < 4) ? 32'sd3 : 32'sd5);
    end
    @(posedge core_clk);
    beam_sector0 <= 1'b0;
    @(posedge core_clk);
    beam_sector0 <= 1'b1;
    draw_active <= 1'b1;
    @(posedge core_clk);
    draw_active <= 1'b0;
    // count from the edge that loads the counter, not one edge later
    #1;
    for (i = 0; i < 8 && settle_wait !== 1'b1; i++) tick(1);
    give_up(i, 8);
    for (n = 0; n < 5000 && settle_wait === 1'b1; n++) tick(1);
    give_up(n, 5000);
    chk(n, csr_pkg::SETTLE_NS / csr_pkg::CLK_NS);
    rd(8'h00, r);
    chk(r, 32'h4);
    dac(1'b1, 10'h2A5);
    dac(1'b0, 10'h15A);
    complete_run();
  end
endmodule : test_console_select_rotate_control
`default_nettype wire
